// ===== include/drive_ctl_regs.vh
`ifndef DRIVE_CTL_REGS_VH
`define DRIVE_CTL_REGS_VH
// Notes on behaviour
// - Power-up auto start needs terminal mode one/two, power-on run set, run active.
// - Without power-on run, a run active at power-up waits for off then on.
// - Power-on start requests speed search when option bit 4 is set.
// - Without speed search, start from 0 Hz and ramp up normally.
// - A fault trip cuts the output at once; the motor coasts.
// - Reset-restart with terminal mode resumes after trip reset, no toggle needed.
// - Auto restart up to 0..10 tries, each after 0..60 s delay.
// - Reset-restart start requests speed search when option bit 2 is set.
// - Max-frequency mode: accel time spans 0 Hz to max frequency (40..400 Hz).
// - Max-frequency mode: decel time spans max frequency down to stop.
// - Ramp reference 0 scales to max frequency, 1 to the present step.
// - Accel and decel times 0.0..6000.0 s, defaults 20.0 and 30.0.
// - Time unit 0.01, 0.1 or 1 s; stored count kept on unit change.

// Register byte offsets
`define OFS_CTRL      8'h00
`define OFS_ACC_TIME  8'h04
`define OFS_DEC_TIME  8'h08
`define OFS_MAX_FREQ  8'h0c
`define OFS_TARGET    8'h10
`define OFS_RETRY     8'h14
`define OFS_STATUS    8'h18
`define OFS_OUT_FREQ  8'h1c
`define OFS_IRQ_STAT  8'h20
`define OFS_IRQ_MASK  8'h24

// Control field positions
`define CTRL_SRC_LSB     0
`define CTRL_POR_BIT     3
`define CTRL_RSTR_BIT    4
`define CTRL_REF_BIT     5
`define CTRL_SCALE_LSB   6
`define CTRL_SS_LSB      8
`define SS_POWERON_BIT   4
`define SS_RESTART_BIT   2
`define RETRY_DLY_LSB    4

// Command source codes
`define SRC_TERM_ONE     3'h1
`define SRC_TERM_TWO     3'h2

// Reset values and write limits
`define CTRL_RST      32'h0000_0041
`define ACC_RST       16'h00c8
`define DEC_RST       16'h012c
`define MAXF_RST      16'h1770
`define MAXF_MIN      16'h0fa0
`define MAXF_MAX      16'h9c40
`define TIME_MAX      16'hea60
`define RETRY_RST     16'h00a0
`define RETRY_CNT_MAX 4'ha
`define RETRY_DLY_MAX 12'h258

// Timing
`define CLK_PERIOD_NS 40
`define UNIT_NS       10000000
`define UNIT_CYCLES   (`UNIT_NS / `CLK_PERIOD_NS)
`define SETTLE_CYCLES 4'h8

// Interrupt status bits
`define IRQ_TRIP      0
`define IRQ_RESTART   1
`define IRQ_REACHED   2
`endif

// ===== rtl/drive_start_restart_ramp_control.v
`timescale 1ns/1ps
`include "drive_ctl_regs.vh"
module drive_start_restart_ramp_control #(
    parameter UNIT_CYCLES = `UNIT_CYCLES
) (
    input  wire        mclk_i,
    input  wire        reset_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [7:0]  paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    input  wire        run_cmd_i,
    input  wire        fault_trip_i,
    input  wire        fault_reset_i,
    output reg         output_enable_o,
    output reg         speed_search_o,
    output reg  [15:0] freq_o,
    output reg         irq_o
);
    // ************************************************
    // States
    // ************************************************
    localparam [2:0] ST_SETTLE = 3'd0;
    localparam [2:0] ST_IDLE   = 3'd1;
    localparam [2:0] ST_WOFF   = 3'd2;
    localparam [2:0] ST_RUN    = 3'd3;
    localparam [2:0] ST_TRIP   = 3'd4;
    localparam [2:0] ST_RETRY  = 3'd5;

    // ************************************************
    // Pin synchronisers
    // ************************************************
    reg [2:0] s1_q;
    reg [2:0] s2_q;
    reg [2:0] s3_q;
    reg [2:0] pin_q;
    reg [2:0] pin_old_q;
    integer   i;

    always @(posedge mclk_i) begin
        if (reset_i) begin
            s1_q      <= 3'h0;
            s2_q      <= 3'h0;
            s3_q      <= 3'h0;
            pin_q     <= 3'h0;
            pin_old_q <= 3'h0;
        end else begin
            s1_q      <= {fault_reset_i, fault_trip_i, run_cmd_i};
            s2_q      <= s1_q;
            s3_q      <= s2_q;
            pin_old_q <= pin_q;
            for (i = 0; i < 3; i = i + 1) begin
                if (s2_q[i] == s3_q[i]) begin
                    pin_q[i] <= s3_q[i];
                end
            end
        end
    end

    wire run_w      = pin_q[0];
    wire trip_w     = pin_q[1];
    wire freset_w   = pin_q[2] & ~pin_old_q[2];
    wire run_rise_w = pin_q[0] & ~pin_old_q[0];

    // ************************************************
    // Registers
    // ************************************************
    reg [31:0] ctrl_q;
    reg [15:0] acc_q;
    reg [15:0] dec_q;
    reg [15:0] maxf_q;
    reg [15:0] target_q;
    reg [15:0] retry_q;
    reg [2:0]  irq_stat_q;
    reg [2:0]  irq_mask_q;

    wire [2:0] src_w   = ctrl_q[`CTRL_SRC_LSB +: 3];
    wire       term_w  = (src_w == `SRC_TERM_ONE) ||
                         (src_w == `SRC_TERM_TWO);
    wire [1:0] scale_w = ctrl_q[`CTRL_SCALE_LSB +: 2];
    wire [7:0] ss_w    = ctrl_q[`CTRL_SS_LSB +: 8];

    function [15:0] clamp;
        input [15:0] v;
        input [15:0] lo;
        input [15:0] hi;
        begin
            clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
        end
    endfunction

    // ************************************************
    // APB slave: one wait state, then pready
    // ************************************************
    wire acc_phase = psel_i & penable_i;
    wire apb_done  = acc_phase & pready_o;
    wire apb_wr    = apb_done & pwrite_i;
    wire hit_w     = (paddr_i[1:0] == 2'b00) &&
                     (paddr_i[7:2] <= 6'h09);

    reg  [2:0]  irq_set;
    reg         reached_q;
    reg         reached_old_q;
    // Reached event is an edge so a long hold at target counts once
    wire [2:0]  ev_w = irq_set | {reached_q & ~reached_old_q, 2'b00};
    reg  [2:0]  state_q;
    reg  [31:0] rdata;

    always @* begin
        case (paddr_i)
            `OFS_CTRL:     rdata = ctrl_q;
            `OFS_ACC_TIME: rdata = {16'h0000, acc_q};
            `OFS_DEC_TIME: rdata = {16'h0000, dec_q};
            `OFS_MAX_FREQ: rdata = {16'h0000, maxf_q};
            `OFS_TARGET:   rdata = {16'h0000, target_q};
            `OFS_RETRY:    rdata = {16'h0000, retry_q};
            `OFS_STATUS:   rdata = {24'h0, output_enable_o,
                                    speed_search_o, 3'h0, state_q};
            `OFS_OUT_FREQ: rdata = {16'h0000, freq_o};
            `OFS_IRQ_STAT: rdata = {29'h0, irq_stat_q};
            `OFS_IRQ_MASK: rdata = {29'h0, irq_mask_q};
            default:       rdata = 32'h0000_0000;
        endcase
    end

    always @(posedge mclk_i) begin
        if (reset_i) begin
            pready_o   <= 1'b0;
            pslverr_o  <= 1'b0;
            prdata_o   <= 32'h0000_0000;
            ctrl_q     <= `CTRL_RST;
            acc_q      <= `ACC_RST;
            dec_q      <= `DEC_RST;
            maxf_q     <= `MAXF_RST;
            target_q   <= 16'h0000;
            retry_q    <= `RETRY_RST;
            irq_mask_q <= 3'h0;
            irq_stat_q <= 3'h0;
            irq_o      <= 1'b0;
        end else begin
            pready_o  <= acc_phase & ~pready_o;
            pslverr_o <= acc_phase & ~pready_o & ~hit_w;
            if (acc_phase & ~pready_o) begin
                prdata_o <= pwrite_i ? 32'h0000_0000 : rdata;
            end
            if (apb_wr) begin
                case (paddr_i)
                    `OFS_CTRL:     ctrl_q <= {16'h0000, pwdata_i[15:0]};
                    // Unit change keeps the count, so the time rescales
                    `OFS_ACC_TIME: acc_q <= clamp(pwdata_i[15:0],
                                            16'h0000, `TIME_MAX);
                    `OFS_DEC_TIME: dec_q <= clamp(pwdata_i[15:0],
                                            16'h0000, `TIME_MAX);
                    `OFS_MAX_FREQ: maxf_q <= clamp(pwdata_i[15:0],
                                             `MAXF_MIN, `MAXF_MAX);
                    `OFS_TARGET:   target_q <= pwdata_i[15:0];
                    `OFS_RETRY:    retry_q <= {
                        (pwdata_i[15:4] > `RETRY_DLY_MAX) ?
                            `RETRY_DLY_MAX : pwdata_i[15:4],
                        (pwdata_i[3:0] > `RETRY_CNT_MAX) ?
                            `RETRY_CNT_MAX : pwdata_i[3:0]};
                    `OFS_IRQ_MASK: irq_mask_q <= pwdata_i[2:0];
                    default: ;
                endcase
            end
            // New events win over a same-cycle clear
            if (apb_wr && paddr_i == `OFS_IRQ_STAT) begin
                irq_stat_q <= (irq_stat_q & ~pwdata_i[2:0]) | ev_w;
            end else begin
                irq_stat_q <= irq_stat_q | ev_w;
            end
            irq_o <= |((irq_stat_q | ev_w) & irq_mask_q);
        end
    end

    // ************************************************
    // Base tick and start/trip sequencer
    // ************************************************
    reg [31:0] tick_cnt_q;
    reg        tick_q;
    reg [3:0]  settle_q;
    reg [3:0]  tries_q;
    reg [15:0] dly_q;
    reg [3:0]  sub_q;
    reg        run_req_q;
    reg        ramp_rst_q;

    always @(posedge mclk_i) begin
        if (reset_i) begin
            tick_cnt_q <= 32'h0;
            tick_q     <= 1'b0;
        end else if (tick_cnt_q >= UNIT_CYCLES - 1) begin
            tick_cnt_q <= 32'h0;
            tick_q     <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h1;
            tick_q     <= 1'b0;
        end
    end

    always @(posedge mclk_i) begin
        if (reset_i) begin
            state_q         <= ST_SETTLE;
            settle_q        <= 4'h0;
            tries_q         <= 4'h0;
            dly_q           <= 16'h0;
            sub_q           <= 4'h0;
            run_req_q       <= 1'b0;
            ramp_rst_q      <= 1'b1;
            output_enable_o <= 1'b0;
            speed_search_o  <= 1'b0;
            irq_set         <= 3'h0;
        end else begin
            speed_search_o <= 1'b0;
            ramp_rst_q     <= 1'b0;
            irq_set        <= 3'h0;
            if (trip_w && state_q != ST_TRIP && state_q != ST_RETRY) begin
                // Cut at once, motor coasts; ramp restarts at 0 Hz
                state_q         <= ST_TRIP;
                output_enable_o <= 1'b0;
                run_req_q       <= 1'b0;
                ramp_rst_q      <= 1'b1;
                irq_set[`IRQ_TRIP] <= 1'b1;
            end else begin
                case (state_q)
                    ST_SETTLE: begin
                        // Let the pin filters fill before judging power-up
                        settle_q <= settle_q + 4'h1;
                        tries_q  <= retry_q[3:0];
                        if (settle_q == `SETTLE_CYCLES) begin
                            if (run_w && term_w &&
                                ctrl_q[`CTRL_POR_BIT]) begin
                                state_q         <= ST_RUN;
                                output_enable_o <= 1'b1;
                                speed_search_o  <=
                                    ss_w[`SS_POWERON_BIT];
                            end else if (run_w) begin
                                state_q <= ST_WOFF;
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end
                    end
                    ST_WOFF: begin
                        if (!run_w) begin
                            state_q <= ST_IDLE;
                        end
                    end
                    ST_IDLE: begin
                        run_req_q <= 1'b0;
                        if (run_rise_w) begin
                            // Plain start: V/F from standstill
                            state_q         <= ST_RUN;
                            output_enable_o <= 1'b1;
                            tries_q         <= retry_q[3:0];
                        end
                    end
                    ST_RUN: begin
                        run_req_q <= run_w;
                        if (!run_w && freq_o == 16'h0000) begin
                            state_q         <= ST_IDLE;
                            output_enable_o <= 1'b0;
                        end
                    end
                    ST_TRIP: begin
                        if (!trip_w && tries_q != 4'h0) begin
                            state_q <= ST_RETRY;
                            dly_q   <= {4'h0, retry_q[15:4]};
                            sub_q   <= 4'h0;
                        end else if (!trip_w && freset_w) begin
                            tries_q <= retry_q[3:0];
                            if (ctrl_q[`CTRL_RSTR_BIT] && term_w &&
                                run_w) begin
                                state_q         <= ST_RUN;
                                output_enable_o <= 1'b1;
                                speed_search_o  <=
                                    ss_w[`SS_RESTART_BIT];
                                irq_set[`IRQ_RESTART] <= 1'b1;
                            end else if (run_w) begin
                                state_q <= ST_WOFF;
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end
                    end
                    ST_RETRY: begin
                        // Delay counts 0.1 s steps of ten base ticks
                        if (trip_w) begin
                            state_q <= ST_TRIP;
                        end else if (dly_q == 16'h0) begin
                            tries_q <= tries_q - 4'h1;
                            if (run_w) begin
                                state_q         <= ST_RUN;
                                output_enable_o <= 1'b1;
                                speed_search_o  <= ss_w[`SS_RESTART_BIT];
                                irq_set[`IRQ_RESTART] <= 1'b1;
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end else if (tick_q) begin
                            if (sub_q == 4'h9) begin
                                sub_q <= 4'h0;
                                dly_q <= dly_q - 16'h1;
                            end else begin
                                sub_q <= sub_q + 4'h1;
                            end
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // ************************************************
    // Linear ramp generator
    // ************************************************
    // Error accumulator may move several steps per clock; a zero time
    // jumps straight to the goal.
    reg  [15:0] seg_base_q;
    reg  [15:0] goal_old_q;
    reg  [47:0] err_q;
    reg  [47:0] period;
    reg  [15:0] span;
    reg  [15:0] rtime;
    reg  [47:0] sum;
    reg  [47:0] steps;
    reg  [15:0] nxt;
    wire [15:0] goal_w = run_req_q ?
                         ((target_q > maxf_q) ? maxf_q : target_q) :
                         16'h0000;
    wire        up_w   = goal_w > freq_o;

    always @* begin
        rtime = up_w ? acc_q : dec_q;
        case (scale_w)
            2'd0:    period = rtime * UNIT_CYCLES;
            2'd1:    period = rtime * UNIT_CYCLES * 10;
            default: period = rtime * UNIT_CYCLES * 100;
        endcase
        if (ctrl_q[`CTRL_REF_BIT]) begin
            span = (goal_w > seg_base_q) ? goal_w - seg_base_q :
                                           seg_base_q - goal_w;
        end else begin
            span = maxf_q;
        end
        sum = err_q + {32'h0, span};
        if (period == 48'h0) begin
            steps = 48'h0;
        end else begin
            steps = sum / period;
        end
        if (up_w) begin
            nxt = (steps >= {32'h0, goal_w - freq_o}) ? goal_w :
                  freq_o + steps[15:0];
        end else begin
            nxt = (steps >= {32'h0, freq_o - goal_w}) ? goal_w :
                  freq_o - steps[15:0];
        end
    end

    always @(posedge mclk_i) begin
        if (reset_i) begin
            freq_o     <= 16'h0000;
            seg_base_q <= 16'h0000;
            goal_old_q <= 16'h0000;
            err_q      <= 48'h0;
            reached_q  <= 1'b1;
        end else if (ramp_rst_q) begin
            freq_o     <= 16'h0000;
            seg_base_q <= 16'h0000;
            goal_old_q <= 16'h0000;
            err_q      <= 48'h0;
        end else if (goal_w != goal_old_q) begin
            // New step: remember where it starts
            goal_old_q <= goal_w;
            seg_base_q <= freq_o;
            err_q      <= 48'h0;
            reached_q  <= 1'b0;
        end else if (freq_o == goal_w) begin
            err_q <= 48'h0;
            if (!reached_q && output_enable_o) begin
                reached_q <= 1'b1;
            end
        end else if (period == 48'h0) begin
            freq_o <= goal_w;
        end else begin
            err_q  <= sum - steps * period;
            freq_o <= nxt;
        end
    end

    always @(posedge mclk_i) begin
        if (reset_i) begin
            reached_old_q <= 1'b1;
        end else begin
            reached_old_q <= reached_q;
        end
    end
endmodule // drive_start_restart_ramp_control

// ===== verification/drive_ctl_assertions.sv
`timescale 1ns/1ps
// ****
// Port checker
// ****
module drive_ctl_checker (
    input wire        mclk_i,
    input wire        reset_i,
    input wire        psel_i,
    input wire        penable_i,
    input wire        pready_o,
    input wire        pslverr_o,
    input wire        run_cmd_i,
    input wire        fault_trip_i,
    input wire        output_enable_o,
    input wire        speed_search_o,
    input wire [15:0] freq_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    a_ready_one_wait: assert property (
        psel_i && penable_i && !pready_o |=> pready_o)
        else $error("ready did not follow the first access cycle");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready stood longer than one cycle");
    a_ready_access: assert property (pready_o |-> psel_i && penable_i)
        else $error("ready outside an access phase");
    a_error_with_ready: assert property (pslverr_o |-> pready_o)
        else $error("error flag without ready");
    a_trip_cuts_output: assert property (
        fault_trip_i [*8] |-> !output_enable_o)
        else $error("output still on during a trip");
    a_search_pulse: assert property (
        speed_search_o |=> !speed_search_o)
        else $error("search request longer than one cycle");
    a_enable_cause: assert property (
        $rose(output_enable_o) |-> $past(run_cmd_i, 3))
        else $error("output started without a run command");
    a_rest_after_reset: assert property (
        $fell(reset_i) |-> !output_enable_o && freq_o == 16'h0000)
        else $error("output not at rest after reset");
    c_search: cover property ($rose(speed_search_o));
    c_bus_error: cover property (pslverr_o);
    c_stop: cover property ($fell(output_enable_o));
endmodule // drive_ctl_checker

bind drive_start_restart_ramp_control drive_ctl_checker u_chk (
    .mclk_i(mclk_i), .reset_i(reset_i), .psel_i(psel_i),
    .penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .run_cmd_i(run_cmd_i), .fault_trip_i(fault_trip_i),
    .output_enable_o(output_enable_o), .speed_search_o(speed_search_o),
    .freq_o(freq_o));

// ===== verification/term_block_model.sv
`timescale 1ns/1ps
// ****
// Terminal block and trip source
// ****
module term_block_model (
    input  wire mclk_i,
    output reg  run_cmd_o,
    output reg  fault_trip_o,
    output reg  fault_reset_o
);
    initial begin
        run_cmd_o = 1'b0;
        fault_trip_o = 1'b0;
        fault_reset_o = 1'b0;
    end
    // Pins are filtered, so each level lasts several clocks
    task set_run(input logic v, input int n);
        @(posedge mclk_i);
        run_cmd_o <= v;
        repeat (n) @(posedge mclk_i);
    endtask
    task trip(input int n);
        @(posedge mclk_i);
        fault_trip_o <= 1'b1;
        repeat (n) @(posedge mclk_i);
        fault_trip_o <= 1'b0;
    endtask
    // Trip already low here; a reset edge during a trip is void
    task reset_trip(input int n);
        repeat (n) @(posedge mclk_i);
        fault_reset_o <= 1'b1;
        repeat (6) @(posedge mclk_i);
        fault_reset_o <= 1'b0;
    endtask
    task toggle_run(input int n);
        set_run(1'b0, n);
        set_run(1'b1, 0);
    endtask
endmodule // term_block_model

// ===== verification/tb.sv
`timescale 1ns/1ps
`include "drive_ctl_regs.vh"
module tb;
    typedef struct packed {
        logic [31:0] d;
        logic [31:0] m;
        logic        e;
    } note_t;
    logic        mclk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0000_0000;
    wire  [31:0] prdata_o;
    wire         pready_o;
    wire         pslverr_o;
    wire         run_cmd_i;
    wire         fault_trip_i;
    wire         fault_reset_i;
    wire         output_enable_o;
    wire         speed_search_o;
    wire  [15:0] freq_o;
    wire         irq_o;
    note_t       notes[$];
    note_t       nt;
    int          fails = 0;
    int          n_checks = 0;
    int          i;
    logic [31:0] seed = 32'heed09438;
    logic [31:0] r;
    logic [7:0]  ofs[5] = '{`OFS_CTRL, `OFS_ACC_TIME, `OFS_DEC_TIME,
                            `OFS_MAX_FREQ, `OFS_RETRY};
    logic [31:0] rstv[5] = '{32'h0000_0041, 32'h0000_00c8, 32'h0000_012c,
                             32'h0000_1770, 32'h0000_00a0};
    logic [31:0] ctl[3] = '{32'h0000_0001, 32'h0000_0021, 32'h0000_0041};
    int          alo[3] = '{7, 12, 48};
    int          ahi[3] = '{15, 19, 62};
    int          dlo[3] = '{11, 20, 95};
    int          dhi[3] = '{20, 30, 115};

    always #20 mclk_i = ~mclk_i;

    drive_start_restart_ramp_control #(.UNIT_CYCLES(10)) dut (
        .mclk_i(mclk_i), .reset_i(reset_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .run_cmd_i(run_cmd_i),
        .fault_trip_i(fault_trip_i), .fault_reset_i(fault_reset_i),
        .output_enable_o(output_enable_o),
        .speed_search_o(speed_search_o), .freq_o(freq_o), .irq_o(irq_o));
    term_block_model pins (
        .mclk_i(mclk_i), .run_cmd_o(run_cmd_i),
        .fault_trip_o(fault_trip_i), .fault_reset_o(fault_reset_i));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task chk(input logic [32:0] got, input logic [32:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time,
                     got, exp);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task do_reset;
        reset_i <= 1'b1;
        repeat (5) @(posedge mclk_i);
        reset_i <= 1'b0;
    endtask
    // ****
    // Bus master; the note for the monitor is queued at setup
    // ****
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             input logic [31:0] m, input logic e);
        @(posedge mclk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        notes.push_back({d, m, e});
        @(posedge mclk_i);
        penable_i <= 1'b1;
        do @(posedge mclk_i); while (pready_o !== 1'b1);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0000_0000, 1'b0);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
        apb(1'b0, a, d, m, 1'b0);
    endtask
    // Kind 0 enable level, 1 frequency value, 2 search pulse
    task wait_on(input int k, input logic [15:0] v, input logic want,
                 input int lo, input int hi);
        int   n;
        logic met;
        n = 0;
        met = 1'b0;
        while (n < hi && !met) begin
            met = (k == 0 && output_enable_o === v[0]) ||
                  (k == 1 && freq_o === v) ||
                  (k == 2 && speed_search_o === 1'b1);
            if (!met) begin
                @(posedge mclk_i);
                n++;
            end
        end
        chk({1'b0, 32'(met == want && n >= lo)}, 33'h1);
    endtask

    always @(posedge mclk_i) begin
        if (psel_i && penable_i && pready_o === 1'b1) begin
            nt = notes.pop_front();
            chk({pslverr_o, prdata_o & nt.m}, {nt.e, nt.d & nt.m});
        end
    end
    // Whole run is some seven hundred cycles
    initial begin
        repeat (20000) @(posedge mclk_i);
        fails++;
        test_done;
    end

    initial begin
        pins.set_run(1'b1, 0);
        do_reset;
        for (i = 0; i < 5; i++)
            rd(ofs[i], rstv[i], 32'hffff_ffff);
        apb(1'b0, 8'h40, 32'h0, 32'hffff_ffff, 1'b1);
        for (i = 0; i < 3; i++) begin
            r = xs();
            wr(`OFS_IRQ_MASK, r);
            rd(`OFS_IRQ_MASK, r, 32'h0000_0007);
        end
        wait_on(0, 16'h0001, 1'b0, 0, 40);
        pins.toggle_run(6);
        wait_on(0, 16'h0001, 1'b1, 2, 20);
        chk({17'h0, freq_o}, 33'h0);
        $display("test 1 done");
        pins.set_run(1'b0, 0);
        wait_on(0, 16'h0000, 1'b1, 0, 400);
        wr(`OFS_TARGET, 32'h0000_0bb8);
        wr(`OFS_ACC_TIME, 32'h0000_0001);
        wr(`OFS_DEC_TIME, 32'h0000_0002);
        for (i = 0; i < 3; i++) begin
            wr(`OFS_CTRL, ctl[i]);
            pins.set_run(1'b1, 0);
            wait_on(1, 16'h0bb8, 1'b1, alo[i], ahi[i]);
            pins.set_run(1'b0, 0);
            wait_on(1, 16'h0000, 1'b1, dlo[i], dhi[i]);
            wait_on(0, 16'h0000, 1'b1, 0, 20);
        end
        $display("test 2 done");
        wr(`OFS_IRQ_MASK, 32'h0000_0001);
        pins.set_run(1'b1, 0);
        wait_on(0, 16'h0001, 1'b1, 0, 30);
        pins.trip(10);
        chk({32'h0, output_enable_o}, 33'h0);
        chk({32'h0, irq_o}, 33'h1);
        rd(`OFS_IRQ_STAT, 32'h0000_0001, 32'h0000_0001);
        wr(`OFS_IRQ_STAT, 32'h0000_0001);
        rd(`OFS_IRQ_STAT, 32'h0000_0000, 32'h0000_0001);
        chk({32'h0, irq_o}, 33'h0);
        pins.reset_trip(4);
        wait_on(0, 16'h0001, 1'b0, 0, 60);
        pins.toggle_run(6);
        wait_on(0, 16'h0001, 1'b1, 0, 30);
        $display("test 3 done");
        wr(`OFS_IRQ_MASK, 32'h0000_0000);
        wr(`OFS_CTRL, 32'h0000_0451);
        pins.trip(10);
        chk({32'h0, irq_o}, 33'h0);
        pins.reset_trip(4);
        wait_on(2, 16'h0000, 1'b1, 0, 40);
        wait_on(0, 16'h0001, 1'b1, 0, 20);
        $display("test 4 done");
        wr(`OFS_CTRL, 32'h0000_0041);
        wr(`OFS_RETRY, 32'h0000_0011);
        // Retry count loads only at power-up settle, a fresh start or a fault reset
        pins.set_run(1'b0, 0);
        wait_on(0, 16'h0000, 1'b1, 0, 400);
        pins.set_run(1'b1, 0);
        wait_on(0, 16'h0001, 1'b1, 0, 30);
        pins.trip(6);
        wait_on(0, 16'h0001, 1'b0, 0, 50);
        wait_on(0, 16'h0001, 1'b1, 0, 200);
        $display("test 5 done");
        do_reset;
        wr(`OFS_CTRL, 32'h0000_1049);
        wait_on(2, 16'h0000, 1'b1, 0, 40);
        wait_on(0, 16'h0001, 1'b1, 0, 20);
        $display("test 6 done");
        test_done;
    end
endmodule // tb
